// [hw/csp_clock_control.sv]
// clock source selection, start-up timing, rc trim and glitch-free system clock prescaler
//
// Summary of operation
// - low-frequency crystal: start-up fuses 00 none, 01 4.1 ms, 10 65 ms, 11 reserved (the logic gives 11 the 65 ms delay too).
// - low-frequency crystal: select bit 0 picks 1K or 32K wake cycles; bit 1 capacitors.
// - select fuses 0010 choose the internal 8.0 MHz rc oscillator.
// - programmed divide-by-eight fuse starts the system clock divided by 8.
// - every reset loads the factory calibration byte into the trim register.
// - rc oscillator: wake takes 6 cycles; reset delay none, 4.1 ms, 65 ms.
// - reset time-out is always timed by the separate watchdog oscillator.
// - trim register bit 7 is reserved and reads zero.
// - seven trim bits set rc frequency monotonically, 0 lowest, 0x7f highest.
// - select fuses 0000 choose the external clock, 6 cycle wake.
// - programmed clock-output fuse drives system clock on port b bit 0, reset included.
// - the pin carries the clock after prescaler division.
// - cpu, io and flash clocks divide together; async timer only when synchronous.
// - changing division gives no glitch and no frequency above old or new.
// - prescaler is a counter on the undivided clock, its state unreadable.
// - new rate active after one old period plus one to two new periods.
// - unlock write alone, then within four cycles division write with unlock clear.
// - unlock clears after four cycles or on division write, and blocks interrupts.
// - division field 0000..1000 divides by 1..256 in powers of two; rest reserved.
// - division field resets to 0000, or 0011 with divide-by-eight fuse programmed.
// - select fuses: 1xxx crystal, 01xx low-frequency crystal, 0010 rc, 0000 external.
`timescale 1ns/10ps
`include "csp_map.svh"
module csp_clock_control
    import csp_pkg::*;
#(
    parameter int RST_SHORT_WDT = `CSP_RST_4K_WDT,
    parameter int RST_LONG_WDT = `CSP_RST_64K_WDT,
    parameter int WAKE_16K_CK = `CSP_WAKE_16KCK,
    parameter int WAKE_32K_CK = `CSP_WAKE_32KCK
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fuses, calibration byte and watchdog oscillator (asynchronous)
    input wire logic [3:0] clock_source_select_fuses_i,
    input wire logic [1:0] startup_time_fuses_i,
    input wire logic initial_divide_by_eight_fuse_i,
    input wire logic clock_output_fuse_i,
    input wire logic [6:0] factory_cal_i,
    input wire logic wdt_osc_i,
    // core side
    input wire logic wake_req_i,
    input wire logic async_timer_sync_mode_i,
    input wire logic port_b0_data_i,
    input wire logic port_b0_oe_n_i,
    // clock enables and status
    output logic cpu_clk_en_o,
    output logic io_clk_en_o,
    output logic flash_clk_en_o,
    output logic async_timer_clk_en_o,
    output logic core_rst_n_o,
    output logic cpu_hold_o,
    output logic irq_block_o,
    output logic [6:0] rc_trim_o,
    output logic lf_caps_en_o,
    output csp_src_e clock_source_o,
    // port b bit 0 pin
    output logic port_b0_o,
    output logic port_b0_oe_n_o
);
    generate
        if (RST_SHORT_WDT < 1 || RST_LONG_WDT > 131071 || WAKE_16K_CK < 1 || WAKE_32K_CK > 131071)
        begin : g_bad
            $error("csp_clock_control: count parameter out of range");
        end
    endgenerate

    localparam logic [16:0] RST_SHORT = 17'(RST_SHORT_WDT);
    localparam logic [16:0] RST_LONG = 17'(RST_LONG_WDT);
    localparam logic [16:0] WAKE_16K = 17'(WAKE_16K_CK);
    localparam logic [16:0] WAKE_32K = 17'(WAKE_32K_CK);

    // two-stage synchroniser for every pin-side input
    logic [15:0] pin_meta_q;
    logic [15:0] pin_sync_q;
    always_ff @(posedge clk_sys_i) begin
        pin_meta_q <= {wdt_osc_i, factory_cal_i, clock_output_fuse_i,
                       initial_divide_by_eight_fuse_i, startup_time_fuses_i,
                       clock_source_select_fuses_i};
        pin_sync_q <= pin_meta_q;
    end

    // fuse capture; held constant once reset is released
    logic [3:0] clock_source_select_fuses_q;
    logic [1:0] sut_q;
    logic div8_n_q;
    logic clock_output_fuse_n_q;
    csp_src_e src_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            clock_source_select_fuses_q <= pin_sync_q[3:0];
            sut_q <= pin_sync_q[5:4];
            div8_n_q <= pin_sync_q[6];
            clock_output_fuse_n_q <= pin_sync_q[7];
            // reserved 0011/0001 fall back to the internal rc
            if (pin_sync_q[3]) begin
                src_q <= CSP_SRC_XTAL;
            end else if (pin_sync_q[2]) begin
                src_q <= CSP_SRC_LF;
            end else if (pin_sync_q[3:0] == `CSP_FUSE_EXT) begin
                src_q <= CSP_SRC_EXT;
            end else begin
                src_q <= CSP_SRC_RC;
            end
        end
    end

    // start-up lengths: reset delay in watchdog cycles, wake in source cycles
    logic [16:0] rst_len;
    logic [16:0] wake_len;
    always_comb begin
        rst_len = (sut_q == 2'b00) ? 17'h00000 : (sut_q == 2'b01) ? RST_SHORT : RST_LONG;
        wake_len = `CSP_WAKE_6CK;
        case (src_q)
            CSP_SRC_LF: begin
                wake_len = clock_source_select_fuses_q[0] ? WAKE_32K : `CSP_WAKE_1KCK;
            end
            CSP_SRC_XTAL: begin
                case ({clock_source_select_fuses_q[0], sut_q})
                    3'b000, 3'b011, 3'b110: rst_len = RST_SHORT;
                    3'b001, 3'b100, 3'b111: rst_len = RST_LONG;
                    default: rst_len = 17'h00000;
                endcase
                if (!clock_source_select_fuses_q[0]) begin
                    wake_len = sut_q[1] ? `CSP_WAKE_1KCK : `CSP_WAKE_258CK;
                end else begin
                    wake_len = (sut_q == 2'b00) ? `CSP_WAKE_1KCK : WAKE_16K;
                end
            end
            default: begin
                wake_len = `CSP_WAKE_6CK;
            end
        endcase
    end

    // watchdog oscillator edge; the reset time-out never counts the system clock
    logic wdt_d1_q;
    logic wdt_edge;
    always_ff @(posedge clk_sys_i) begin
        wdt_d1_q <= pin_sync_q[15];
    end
    assign wdt_edge = pin_sync_q[15] & ~wdt_d1_q;

    // start-up state machine
    csp_state_e st_q;
    csp_state_e st_d;
    logic [16:0] dcnt_q;
    logic [16:0] dcnt_d;
    always_comb begin
        st_d = st_q;
        dcnt_d = dcnt_q;
        case (st_q)
            CSP_ST_RESET: begin
                dcnt_d = rst_len;
                st_d = (rst_len == 17'h00000) ? CSP_ST_RUN : CSP_ST_DELAY;
            end
            CSP_ST_DELAY: begin
                if (wdt_edge) begin
                    dcnt_d = dcnt_q - 17'h00001;
                    st_d = (dcnt_q == 17'h00001) ? CSP_ST_RUN : CSP_ST_DELAY;
                end
            end
            CSP_ST_RUN: begin
                if (wake_req_i) begin
                    dcnt_d = wake_len;
                    st_d = CSP_ST_WAKE;
                end
            end
            CSP_ST_WAKE: begin
                dcnt_d = dcnt_q - 17'h00001;
                st_d = (dcnt_q == 17'h00001) ? CSP_ST_RUN : CSP_ST_WAKE;
            end
            default: begin
                st_d = CSP_ST_RESET;
            end
        endcase
    end

    // state registers; core stays in reset until the delay has run out
    logic hold_q;
    logic core_rst_n_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_q <= CSP_ST_RESET;
            dcnt_q <= 17'h00000;
            hold_q <= 1'b1;
            core_rst_n_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dcnt_q <= dcnt_d;
            hold_q <= (st_d != CSP_ST_RUN);
            core_rst_n_q <= (st_d == CSP_ST_RUN) || (st_d == CSP_ST_WAKE);
        end
    end

    // apb decode; every access answers in its first access cycle
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic apb_wr;
    logic ctrl_wr;
    logic trim_wr;
    logic setup;
    logic mapped;
    assign setup = psel_i & ~penable_i;
    assign mapped = (paddr_i == `CSP_CTRL_OFS) || (paddr_i == `CSP_TRIM_OFS) ||
                    (paddr_i == `CSP_STAT_OFS);
    assign apb_wr = psel_i & penable_i & pwrite_i & pready_q;
    assign ctrl_wr = apb_wr && (paddr_i == `CSP_CTRL_OFS);
    assign trim_wr = apb_wr && (paddr_i == `CSP_TRIM_OFS);

    // rc trim: calibration reloaded on every reset, msb not stored
    logic [6:0] trim_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            trim_q <= pin_sync_q[14:8];
        end else if (trim_wr) begin
            trim_q <= pwdata_i[6:0];
        end
    end

    // unlock and division select; an unlock write wins over the expiry count
    logic unlock_q;
    logic [2:0] ucnt_q;
    logic pend_q;
    logic [3:0] pend_sel_q;
    logic [3:0] act_sel_q;
    logic pulse_d;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            unlock_q <= 1'b0;
            ucnt_q <= 3'h0;
            pend_q <= 1'b0;
            pend_sel_q <= pin_sync_q[6] ? `CSP_SEL_RST_DIV1 : `CSP_SEL_RST_DIV8;
        end else begin
            if (pulse_d) begin
                pend_q <= 1'b0;
            end
            if (ctrl_wr && pwdata_i[7:0] == `CSP_UNLOCK_WORD) begin
                unlock_q <= 1'b1;
                ucnt_q <= `CSP_UNLOCK_CYC;
            end else if (ctrl_wr && !pwdata_i[`CSP_UNLOCK_BIT] && unlock_q) begin
                unlock_q <= 1'b0;
                // reserved encodings are dropped, the old division stays
                if (pwdata_i[`CSP_SEL_MSB:0] <= `CSP_SEL_MAX) begin
                    pend_q <= 1'b1;
                    pend_sel_q <= pwdata_i[`CSP_SEL_MSB:0];
                end
            end else if (unlock_q && pulse_d) begin
                ucnt_q <= ucnt_q - 3'h1;
                unlock_q <= (ucnt_q != 3'h1);
            end
        end
    end

    // prescaler counter on the undivided clock; the first three reset cycles clear it
    // while the fuse synchroniser fills, later reset cycles keep it running for the pin
    logic [2:0] rst_hist_q;
    logic run_in_rst;
    logic [7:0] cnt_q;
    logic [8:0] sel_hot;
    logic [7:0] mask;
    assign sel_hot = 9'h001 << act_sel_q;
    assign mask = sel_hot[7:0] - 8'h01;
    assign pulse_d = ((cnt_q & mask) == mask);
    assign run_in_rst = !rst_n_i && (rst_hist_q == 3'b000);
    always_ff @(posedge clk_sys_i) begin
        rst_hist_q <= {rst_hist_q[1:0], rst_n_i};
        if (run_in_rst) begin
            cnt_q <= cnt_q + 8'h01;
            act_sel_q <= pin_sync_q[6] ? `CSP_SEL_RST_DIV1 : `CSP_SEL_RST_DIV8;
        end else if (!rst_n_i) begin
            cnt_q <= 8'h00;
            act_sel_q <= pin_sync_q[6] ? `CSP_SEL_RST_DIV1 : `CSP_SEL_RST_DIV8;
        end else if (pulse_d && pend_q) begin
            // switch only at an old-period boundary: no short period can appear
            cnt_q <= 8'h00;
            act_sel_q <= pend_sel_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // clock enables and the pin clock level (one toggle per divided period)
    logic en_q;
    logic asy_en_q;
    logic sys_clk_q;
    always_ff @(posedge clk_sys_i) begin
        if (run_in_rst || rst_n_i) begin
            en_q <= pulse_d & rst_n_i;
            asy_en_q <= async_timer_sync_mode_i ? pulse_d : 1'b1;
            sys_clk_q <= pulse_d ? ~sys_clk_q : sys_clk_q;
        end else begin
            en_q <= 1'b0;
            asy_en_q <= 1'b0;
            sys_clk_q <= 1'b0;
        end
    end

    // port b bit 0: clock overrides the port while the fuse is programmed
    logic pb0_q;
    logic pb0_oe_n_q;
    always_ff @(posedge clk_sys_i) begin
        if (!(rst_n_i ? clock_output_fuse_n_q : pin_sync_q[7])) begin
            pb0_q <= sys_clk_q;
            pb0_oe_n_q <= 1'b0;
        end else begin
            pb0_q <= port_b0_data_i;
            pb0_oe_n_q <= port_b0_oe_n_i;
        end
    end

    // apb answer; the prescaler count itself is never readable
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (setup) begin
                case (paddr_i)
                    `CSP_CTRL_OFS: prdata_q <= {24'h000000, unlock_q, 3'h0, pend_sel_q};
                    `CSP_TRIM_OFS: prdata_q <= {25'h0000000, trim_q};
                    `CSP_STAT_OFS: prdata_q <= {21'h000000, pend_q, act_sel_q, hold_q,
                                                core_rst_n_q, src_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // output assignments
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign cpu_clk_en_o = en_q;
    assign io_clk_en_o = en_q;
    assign flash_clk_en_o = en_q;
    assign async_timer_clk_en_o = asy_en_q;
    assign core_rst_n_o = core_rst_n_q;
    assign cpu_hold_o = hold_q;
    assign irq_block_o = unlock_q;
    assign rc_trim_o = trim_q;
    assign lf_caps_en_o = (src_q == CSP_SRC_LF) && clock_source_select_fuses_q[1];
    assign clock_source_o = src_q;
    assign port_b0_o = pb0_q;
    assign port_b0_oe_n_o = pb0_oe_n_q;

    // checks
    logic [7:0] gap_q;
    logic gap_ok_q;
    logic [10:0] ulive_q;
    // cycles the unlock has stood since last armed; too long for a delay range
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !unlock_q || (ctrl_wr && pwdata_i[7:0] == `CSP_UNLOCK_WORD)) begin
            ulive_q <= 11'h000;
        end else begin
            ulive_q <= ulive_q + 11'h001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            gap_q <= 8'h00;
            gap_ok_q <= 1'b0;
        end else begin
            gap_q <= pulse_d ? 8'h00 : gap_q + 8'h01;
            gap_ok_q <= gap_ok_q | pulse_d;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_trim_msb_zero: assert property (setup && paddr_i == `CSP_TRIM_OFS |=>
        prdata_o[7] == 1'b0 && prdata_o[6:0] == $past(trim_q)) else $error("trim msb set");
    a_unlock_expire: assert property (unlock_q |-> ulive_q < 11'h44c)
        else $error("unlock never expired");
    a_pulse_spacing: assert property (pulse_d && gap_ok_q |-> gap_q == mask)
        else $error("divided period wrong");
    a_change_latency: assert property ($rose(pend_q) |-> ##[1:256] !pend_q)
        else $error("division change late");
    a_pin_clock_out: assert property (!clock_output_fuse_n_q |=> port_b0_o == $past(sys_clk_q)
        && !port_b0_oe_n_o) else $error("pin clock missing");
    a_rc_source: assert property (clock_source_select_fuses_q == `CSP_FUSE_RC |-> src_q == CSP_SRC_RC)
        else $error("rc not selected");
    a_wake_six: assert property ($rose(hold_q) && src_q == CSP_SRC_RC
        |-> hold_q [*6] ##1 !hold_q) else $error("rc wake not 6 cycles");
    a_locked_write: assert property (ctrl_wr && !pwdata_i[7] && !unlock_q
        |=> $stable(pend_sel_q)) else $error("locked write accepted");
    a_div_reset_val: assert property ($rose(core_rst_n_q) && !div8_n_q
        |-> pend_sel_q == `CSP_SEL_RST_DIV8)
        else $error("div8 reset value");
endmodule

// [hw/csp_map.svh]
// register offsets, field positions, reset values and timing counts of the clock block
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH
`define CSP_CTRL_OFS 12'h000
`define CSP_TRIM_OFS 12'h004
`define CSP_STAT_OFS 12'h008
`define CSP_UNLOCK_BIT 7
`define CSP_SEL_MSB 3
`define CSP_UNLOCK_WORD 8'h80
`define CSP_SEL_RST_DIV1 4'h0
`define CSP_SEL_RST_DIV8 4'h3
`define CSP_SEL_MAX 4'h8
`define CSP_UNLOCK_CYC 3'h4
`define CSP_FUSE_EXT 4'h0
`define CSP_FUSE_RC 4'h2
`define CSP_WAKE_6CK 17'h00006
`define CSP_WAKE_258CK 17'h00102
`define CSP_WAKE_1KCK 17'h00400
`define CSP_RST_4K_WDT 4096
`define CSP_RST_64K_WDT 65536
`define CSP_WAKE_16KCK 16384
`define CSP_WAKE_32KCK 32768
`endif

// [hw/csp_pkg.sv]
// types shared by the clock source and prescaler block
package csp_pkg;
    typedef enum logic [3:0] {
        CSP_SRC_XTAL = 4'b0001,
        CSP_SRC_LF = 4'b0010,
        CSP_SRC_RC = 4'b0100,
        CSP_SRC_EXT = 4'b1000
    } csp_src_e;
    typedef enum logic [3:0] {
        CSP_ST_RESET = 4'b0001,
        CSP_ST_DELAY = 4'b0010,
        CSP_ST_RUN = 4'b0100,
        CSP_ST_WAKE = 4'b1000
    } csp_state_e;
endpackage

// [verification/csp_clock_control_tb_top.sv]
// self-checking bench for the clock source and prescaler block
`timescale 1ns/10ps
`include "csp_map.svh"
module csp_clock_control_tb_top
    import csp_pkg::*;
;
    // clock, reset and apb master side
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    // fuse levels (0 = programmed) and core side stimulus
    logic [3:0] sel_f = 4'h2;
    logic [1:0] sut_f = 2'h2;
    logic div8_f = 1'b0;
    logic clock_output_fuse_f = 1'b0;
    logic [6:0] cal_f = 7'h55;
    logic wdt_osc = 1'b0;
    logic [2:0] wdt_cnt = 3'h0;
    logic wake = 1'b0;
    logic amode = 1'b0;
    logic pb_d = 1'b0;
    logic pb_oe_n = 1'b1;
    // design outputs
    logic cpu_en, io_en, fl_en, asy_en, core_rst_n, hold, irq_blk, caps, pb_o, pb_oe_n_o;
    logic [6:0] trim;
    csp_src_e src;
    // bench bookkeeping
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rdat;
    logic rerr;

    // shortened watchdog and wake counts keep the run brief
    csp_clock_control #(.RST_SHORT_WDT(8), .RST_LONG_WDT(16), .WAKE_16K_CK(20),
        .WAKE_32K_CK(40)) uut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .clock_source_select_fuses_i(sel_f),
        .startup_time_fuses_i(sut_f), .initial_divide_by_eight_fuse_i(div8_f),
        .clock_output_fuse_i(clock_output_fuse_f), .factory_cal_i(cal_f), .wdt_osc_i(wdt_osc),
        .wake_req_i(wake), .async_timer_sync_mode_i(amode), .port_b0_data_i(pb_d),
        .port_b0_oe_n_i(pb_oe_n), .cpu_clk_en_o(cpu_en), .io_clk_en_o(io_en),
        .flash_clk_en_o(fl_en), .async_timer_clk_en_o(asy_en), .core_rst_n_o(core_rst_n),
        .cpu_hold_o(hold), .irq_block_o(irq_blk), .rc_trim_o(trim), .lf_caps_en_o(caps),
        .clock_source_o(src), .port_b0_o(pb_o), .port_b0_oe_n_o(pb_oe_n_o));

    // 40 MHz system clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    // watchdog oscillator of 12 system cycles, plus the hang guard
    always @(posedge clk_sys_i) begin
        wdt_cnt <= (wdt_cnt == 3'h5) ? 3'h0 : wdt_cnt + 3'h1;
        if (wdt_cnt == 3'h5) begin
            wdt_osc <= ~wdt_osc;
        end
        cycles++;
        if (cycles == 30000) begin
            errors++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        chk(pready_o, 1);
    endtask

    // cycles between two cpu enable pulses; io and flash must pulse alongside
    task gap(output int g);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        while (cpu_en !== 1'b1 && n < 600) begin
            @(posedge clk_sys_i);
            n++;
        end
        g = 0;
        do begin
            @(posedge clk_sys_i);
            g++;
        end while (cpu_en !== 1'b1 && g < 600);
        chk({io_en, fl_en}, 2'b11);
    endtask

    // fuses change only with reset held, long enough for the synchroniser
    task do_reset(input logic [3:0] s, input logic [1:0] u, input logic d8, input logic [6:0] c);
        int n;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        sel_f <= s; // source changes only under reset
        sut_f <= u;
        div8_f <= d8;
        clock_output_fuse_f <= 1'b1;
        cal_f <= c;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        n = 0;
        while (core_rst_n !== 1'b1 && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(n <= 4, 1);
    endtask

    // wake pulse then count the held cycles
    task t_wake(input int exp);
        int c;
        c = 0;
        @(posedge clk_sys_i);
        wake <= 1'b1;
        @(posedge clk_sys_i);
        wake <= 1'b0;
        @(posedge clk_sys_i);
        while (hold === 1'b1 && c < 2000) begin
            c++;
            @(posedge clk_sys_i);
        end
        chk(c, exp);
        $display("wake test %0d done", exp);
    endtask

    task t_boot;
        int n;
        logic v;
        n = 0;
        while (core_rst_n !== 1'b1 && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(n >= 180 && n <= 215, 1);
        apb(1'b0, `CSP_TRIM_OFS, 32'h0);
        chk(rdat, 32'h0000_0055);
        apb(1'b0, `CSP_CTRL_OFS, 32'h0);
        chk(rdat[7:0], 8'h03);
        chk(src, CSP_SRC_RC);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rerr, rdat[7:0]}, 9'h100);
        gap(n);
        chk(n, 8);
        chk(pb_oe_n_o, 0);
        v = pb_o;
        // the pin toggles once per divided period: half a pin period is 8 cycles here
        repeat (8) @(posedge clk_sys_i);
        chk(pb_o ^ v, 1);
        chk(asy_en, 1);
        amode <= 1'b1;
        gap(n);
        chk(asy_en, 1);
        @(posedge clk_sys_i);
        chk(asy_en, 0);
        apb(1'b1, `CSP_TRIM_OFS, 32'h0000_00ff); // no nonvolatile write runs
        apb(1'b0, `CSP_TRIM_OFS, 32'h0);
        chk({rdat[7:0], 1'b0, trim}, 16'h7f7f);
        $display("boot and trim test done");
    endtask

    // every division code, each change through the unlock sequence
    task t_div;
        int g1, g2, g3, mn, cur;
        cur = 8;
        for (int v = 0; v <= 8; v++) begin
            apb(1'b1, `CSP_CTRL_OFS, `CSP_UNLOCK_WORD); // nothing else runs between
            #1 chk(irq_blk, 1);
            apb(1'b1, `CSP_CTRL_OFS, v);
            #1 chk(irq_blk, 0);
            mn = (cur < (1 << v)) ? cur : (1 << v);
            gap(g1);
            gap(g2);
            gap(g3);
            chk(g1 >= mn && g2 >= mn, 1);
            chk(g3, 1 << v);
            apb(1'b0, `CSP_CTRL_OFS, 32'h0);
            chk(rdat[7:0], v);
            cur = 1 << v;
        end
        $display("division test done");
    endtask

    // reserved code refused, then an unlock left to expire
    task t_refuse;
        apb(1'b1, `CSP_CTRL_OFS, `CSP_UNLOCK_WORD);
        apb(1'b1, `CSP_CTRL_OFS, 32'h0000_0009);
        apb(1'b0, `CSP_CTRL_OFS, 32'h0);
        chk(rdat[7:0], 8'h08);
        apb(1'b1, `CSP_CTRL_OFS, `CSP_UNLOCK_WORD);
        repeat (4 * 256 + 40) @(posedge clk_sys_i);
        chk(irq_blk, 0);
        apb(1'b1, `CSP_CTRL_OFS, 32'h0000_0001);
        apb(1'b0, `CSP_CTRL_OFS, 32'h0);
        chk(rdat[7:0], 8'h08);
        $display("refusal test done");
    endtask

    // external clock, no divide fuse, pin back to its port function
    task t_ext;
        int n;
        do_reset(4'h0, 2'h0, 1'b1, 7'h2a);
        apb(1'b0, `CSP_CTRL_OFS, 32'h0);
        chk(rdat[7:0], 8'h00);
        chk({src, 1'b0, trim}, 12'h82a);
        gap(n);
        chk(n, 1);
        pb_d <= 1'b1;
        pb_oe_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk({pb_o, pb_oe_n_o}, 2'b10);
        t_wake(6);
        $display("external clock test done");
    endtask

    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_boot();
        t_wake(6);
        t_div();
        t_refuse();
        t_ext();
        do_reset(4'h7, 2'h0, 1'b1, 7'h00);
        chk({src, caps}, 5'b00101);
        t_wake(40);
        do_reset(4'h4, 2'h0, 1'b1, 7'h00);
        chk(caps, 0);
        t_wake(1024);
        do_reset(4'hf, 2'h1, 1'b1, 7'h00);
        chk(src, CSP_SRC_XTAL);
        t_wake(20);
        print_verdict();
    end
endmodule
